// ### rtl/acw_pkg.sv
// constants, field layouts and types shared by the comparator window logic
package acw_pkg;

	// --------------------------------------------------------------------
	// register map: printed offsets are word indices, byte address = 4 * index
	// --------------------------------------------------------------------
	localparam int          ADDR_LSB        = 2;      // byte offset bits inside a word
	localparam int          IDX_W           = 3;      // width of a register index
	localparam int          MAP_TOP_BIT     = 5;      // first address bit above the map
	localparam logic [2:0]  IDX_MAIN_CTRL   = 3'h0;   // enable, pad, power, hysteresis
	localparam logic [2:0]  IDX_WINDOW_CTRL = 3'h1;   // window partner selection
	localparam logic [2:0]  IDX_INPUT_CTRL  = 3'h2;   // polarity, initial level, muxes
	localparam logic [2:0]  IDX_REF_LEVEL   = 3'h5;   // internal reference level
	localparam logic [2:0]  IDX_IRQ_CTRL    = 3'h6;   // trigger mode, interrupt enable
	localparam logic [2:0]  IDX_STATUS      = 3'h7;   // window state, match, flag
	localparam logic [7:0]  REG_RESET       = 8'h00;  // reset value of every register

	// --------------------------------------------------------------------
	// field positions
	// --------------------------------------------------------------------
	localparam int MC_RUN_STANDBY = 7;  // run in standby, stored only
	localparam int MC_PAD_OE      = 6;  // pad_output_enable
	localparam int MC_POWER_LSB   = 3;  // power profile, 2 bits
	localparam int MC_HYS_LSB     = 1;  // hysteresis_select, 2 bits
	localparam int MC_ENABLE      = 0;  // comparator enable
	localparam int WC_PARTNER_LSB = 0;  // window_partner_select, 2 bits
	localparam int IC_POLARITY    = 7;  // output polarity
	localparam int IC_INIT_LEVEL  = 6;  // output_initial_level
	localparam int IC_POS_LSB     = 3;  // positive_input_select, 3 bits
	localparam int IC_NEG_LSB     = 0;  // negative_input_select, 3 bits
	localparam int IRQ_MODE_LSB   = 4;  // interrupt_trigger_mode, 2 bits
	localparam int IRQ_ENABLE     = 0;  // compare_interrupt_enable
	localparam int ST_WIN_LSB     = 6;  // window_state, 2 bits
	localparam int ST_MATCH       = 4;  // match_state
	localparam int ST_FLAG        = 0;  // compare_interrupt_flag, write one to clear

	// --------------------------------------------------------------------
	// selections and modes
	// --------------------------------------------------------------------
	localparam int          POS_PIN_COUNT = 4;     // positive analog pins
	localparam int          NEG_PIN_COUNT = 3;     // negative analog pins
	localparam logic [2:0]  NEG_SEL_REF   = 3'h3;  // negative input from reference
	localparam logic [1:0]  WIN_OFF       = 2'h0;  // window function disabled
	localparam logic [1:0]  WIN_NEXT      = 2'h1;  // partner is the next instance
	localparam logic [1:0]  WIN_SECOND    = 2'h2;  // partner is two instances on
	localparam logic [1:0]  TRIG_BOTH     = 2'h0;  // normal: both edges
	localparam logic [1:0]  TRIG_FALL     = 2'h2;  // normal: falling edge
	localparam logic [1:0]  TRIG_RISE     = 2'h3;  // normal: rising edge
	localparam logic [1:0]  TRIG_ABOVE    = 2'h0;  // window: above
	localparam logic [1:0]  TRIG_INSIDE   = 2'h1;  // window: inside
	localparam logic [1:0]  TRIG_BELOW    = 2'h2;  // window: below
	localparam logic [1:0]  TRIG_OUTSIDE  = 2'h3;  // window: outside
	localparam logic [1:0]  HYS_NONE      = 2'h0;  // no hysteresis
	localparam logic [1:0]  HYS_SMALL     = 2'h1;  // small hysteresis
	localparam logic [1:0]  HYS_MEDIUM    = 2'h2;  // medium hysteresis
	localparam int          HYS_SMALL_LSB  = 2;    // hysteresis in input codes
	localparam int          HYS_MEDIUM_LSB = 4;
	localparam int          HYS_LARGE_LSB  = 8;
	localparam int          REF_SHIFT      = 8;    // reference level divided by 256

	// --------------------------------------------------------------------
	// timing
	// --------------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 5000;  // 200 MHz
	localparam int STARTUP_TIME_NS = 1000;  // least start-up time
	localparam int STARTUP_CYCLES  = (STARTUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;

	// window position of the input
	typedef enum logic [1:0] {
		ACW_WIN_ABOVE,
		ACW_WIN_INSIDE,
		ACW_WIN_BELOW
	} acw_win_t;

endpackage

// ### rtl/acw_sync.sv
// two-stage synchroniser for one level
`timescale 1ns/1ps
module acw_sync
(
	input  wire logic pclk,     // clock
	input  wire logic presetn,  // async reset, active low
	input  wire logic d,        // level to be synchronised
	output logic      q         // synchronised level
);

	logic meta_q;  // first stage, read by the second stage only

	// --------------------------------------------------------------------
	// two flip-flops in a row
	// --------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule // acw_sync

// ### rtl/acw_startup.sv
// start-up timer: ready once the enable has stood for CYCLES clocks
`timescale 1ns/1ps
module acw_startup #(
	parameter int CYCLES = 200  // start-up length in clocks
)
(
	input  wire logic pclk,     // clock
	input  wire logic presetn,  // async reset, active low
	input  wire logic en,       // comparator enable
	output logic      ready_q   // start-up over
);

	localparam int CW = $clog2(CYCLES + 1);          // counter width
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);  // final count

	logic [CW-1:0] cnt_q;  // clocks since enable

	// --------------------------------------------------------------------
	// count while enabled, restart when disabled
	// --------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q   <= '0;
			ready_q <= 1'b0;
		end
		else if (!en)
		begin
			cnt_q   <= '0;
			ready_q <= 1'b0;
		end
		else if (!ready_q)
		begin
			// expiry of the count marks the comparator ready
			ready_q <= (cnt_q == LAST);
			cnt_q   <= cnt_q + CW'(1);
		end
	end

endmodule // acw_startup

// ### rtl/acw_comparator_window.sv
// comparator output, window and interrupt logic with its apb registers
`timescale 1ns/1ps
module acw_comparator_window #(
	parameter int W              = 10,                      // analog sample width
	parameter int ADDR_W         = 12,                      // apb address width
	parameter int STARTUP_CYCLES = acw_pkg::STARTUP_CYCLES  // start-up clocks
)
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADDR_W-1:0]      paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [3:0][W-1:0]      positive_analog_pin,
	input  wire logic [2:0][W-1:0]      negative_analog_pin,
	input  wire logic [W-1:0]           vref_level,
	input  wire logic                   partner_comparator_next,
	input  wire logic                   partner_comparator_second,
	output logic                        current_comparator,
	output logic                        cmp_out_pin,
	output logic                        cmp_out_pin_oe,
	output logic                        cmp_event,
	output logic                        cmp_irq,
	output logic      [1:0]             hysteresis_select,
	output logic      [1:0]             power_profile
);

	// --------------------------------------------------------------------
	// register fields
	// --------------------------------------------------------------------
	logic             en_q;        // comparator enable
	logic             pad_oe_q;    // pad_output_enable
	logic             stby_q;      // run in standby, stored only
	logic [1:0]       power_q;     // power profile
	logic [1:0]       hys_q;       // hysteresis_select
	logic [1:0]       partner_q;   // window_partner_select
	logic             pol_q;       // output polarity
	logic             init_q;      // output_initial_level
	logic [2:0]       pos_sel_q;   // positive_input_select
	logic [2:0]       neg_sel_q;   // negative_input_select
	logic [7:0]       ref_lvl_q;   // reference_level
	logic [1:0]       mode_q;      // interrupt_trigger_mode
	logic             irq_en_q;    // compare_interrupt_enable
	logic             flag_q;      // compare_interrupt_flag
	acw_pkg::acw_win_t win_q;      // window_state
	logic             match_q;     // match_state
	logic             match_p_q;   // match_state one clock back

	// --------------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------------
	logic [2:0]  idx;     // register index
	logic        hit;     // address maps to a register
	logic        wr;      // write takes effect this edge
	logic [7:0]  rd_d;    // read value
	logic [7:0]  wb;      // write byte

	assign idx = paddr[acw_pkg::ADDR_LSB +: acw_pkg::IDX_W];
	assign wb  = pwdata[7:0];
	assign wr  = psel && penable && pwrite && pready && hit;

	// index and alignment check
	always_comb
	begin
		hit = (paddr[acw_pkg::ADDR_LSB-1:0] == '0)
			&& (paddr[ADDR_W-1:acw_pkg::MAP_TOP_BIT] == '0);
		case (idx)
			acw_pkg::IDX_MAIN_CTRL, acw_pkg::IDX_WINDOW_CTRL,
			acw_pkg::IDX_INPUT_CTRL, acw_pkg::IDX_REF_LEVEL,
			acw_pkg::IDX_IRQ_CTRL, acw_pkg::IDX_STATUS: ;
			default: hit = 1'b0;  // holes in the map
		endcase
	end

	// read multiplexer; unused bits read zero
	always_comb
	begin
		rd_d = acw_pkg::REG_RESET;
		case (idx)
			acw_pkg::IDX_MAIN_CTRL:
			begin
				rd_d[acw_pkg::MC_RUN_STANDBY]     = stby_q;
				rd_d[acw_pkg::MC_PAD_OE]          = pad_oe_q;
				rd_d[acw_pkg::MC_POWER_LSB +: 2]  = power_q;
				rd_d[acw_pkg::MC_HYS_LSB +: 2]    = hys_q;
				rd_d[acw_pkg::MC_ENABLE]          = en_q;
			end
			acw_pkg::IDX_WINDOW_CTRL: rd_d[acw_pkg::WC_PARTNER_LSB +: 2] = partner_q;
			acw_pkg::IDX_INPUT_CTRL:
			begin
				rd_d[acw_pkg::IC_POLARITY]        = pol_q;
				rd_d[acw_pkg::IC_INIT_LEVEL]      = init_q;
				rd_d[acw_pkg::IC_POS_LSB +: 3]    = pos_sel_q;
				rd_d[acw_pkg::IC_NEG_LSB +: 3]    = neg_sel_q;
			end
			acw_pkg::IDX_REF_LEVEL: rd_d = ref_lvl_q;
			acw_pkg::IDX_IRQ_CTRL:
			begin
				rd_d[acw_pkg::IRQ_MODE_LSB +: 2]  = mode_q;
				rd_d[acw_pkg::IRQ_ENABLE]         = irq_en_q;
			end
			acw_pkg::IDX_STATUS:
			begin
				rd_d[acw_pkg::ST_WIN_LSB +: 2]    = win_q;
				rd_d[acw_pkg::ST_MATCH]           = match_q;
				rd_d[acw_pkg::ST_FLAG]            = flag_q;
			end
			default: rd_d = acw_pkg::REG_RESET;
		endcase
	end

	// answer one clock after setup: ready, data and error from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			if (psel && !penable && !pwrite && hit)
				prdata <= {24'h0000_00, rd_d};
			else if (psel && !penable)
				prdata <= '0;
		end
	end

	// --------------------------------------------------------------------
	// configuration registers
	// --------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{stby_q, pad_oe_q, power_q, hys_q, en_q} <= '0;
			partner_q <= acw_pkg::WIN_OFF;
			{pol_q, init_q, pos_sel_q, neg_sel_q}    <= '0;
			ref_lvl_q <= acw_pkg::REG_RESET;
			{mode_q, irq_en_q}                       <= '0;
		end
		else if (wr)
		begin
			case (idx)
				acw_pkg::IDX_MAIN_CTRL:
				begin
					stby_q   <= wb[acw_pkg::MC_RUN_STANDBY];
					pad_oe_q <= wb[acw_pkg::MC_PAD_OE];
					power_q  <= wb[acw_pkg::MC_POWER_LSB +: 2];
					hys_q    <= wb[acw_pkg::MC_HYS_LSB +: 2];
					en_q     <= wb[acw_pkg::MC_ENABLE];
				end
				acw_pkg::IDX_WINDOW_CTRL: partner_q <= wb[acw_pkg::WC_PARTNER_LSB +: 2];
				acw_pkg::IDX_INPUT_CTRL:
				begin
					pol_q     <= wb[acw_pkg::IC_POLARITY];
					init_q    <= wb[acw_pkg::IC_INIT_LEVEL];
					pos_sel_q <= wb[acw_pkg::IC_POS_LSB +: 3];
					neg_sel_q <= wb[acw_pkg::IC_NEG_LSB +: 3];
				end
				acw_pkg::IDX_REF_LEVEL: ref_lvl_q <= wb;
				acw_pkg::IDX_IRQ_CTRL:
				begin
					mode_q   <= wb[acw_pkg::IRQ_MODE_LSB +: 2];
					irq_en_q <= wb[acw_pkg::IRQ_ENABLE];
				end
				default: ;  // status is read-only apart from the flag
			endcase
		end
	end

	// --------------------------------------------------------------------
	// input selection, reference and comparison
	// --------------------------------------------------------------------
	logic [W+7:0] ref_prod;  // level times vref
	logic [W-1:0] ref_v;     // internal reference voltage
	logic [W-1:0] pos_v;     // selected positive input
	logic [W-1:0] neg_v;     // selected negative input
	logic         sel_ok;    // both selections legal
	logic [W:0]   hys_v;     // hysteresis in input codes
	logic         raw_d;     // raw comparison
	logic         raw_s;     // synchronised raw comparison
	logic         ready_q;   // start-up over

	assign ref_prod = (W+8)'(ref_lvl_q) * (W+8)'(vref_level);
	assign ref_v    = ref_prod[acw_pkg::REF_SHIFT +: W];

	// reserved selections give a low result
	always_comb
	begin
		pos_v  = positive_analog_pin[pos_sel_q[1:0]];
		neg_v  = negative_analog_pin[0];
		sel_ok = (32'(pos_sel_q) < acw_pkg::POS_PIN_COUNT);
		if (32'(neg_sel_q) < acw_pkg::NEG_PIN_COUNT)
			neg_v = negative_analog_pin[neg_sel_q[1:0]];
		else if (neg_sel_q == acw_pkg::NEG_SEL_REF)
			neg_v = ref_v;
		else
			sel_ok = 1'b0;
		case (hys_q)
			acw_pkg::HYS_NONE:   hys_v = '0;
			acw_pkg::HYS_SMALL:  hys_v = (W+1)'(acw_pkg::HYS_SMALL_LSB);
			acw_pkg::HYS_MEDIUM: hys_v = (W+1)'(acw_pkg::HYS_MEDIUM_LSB);
			default:             hys_v = (W+1)'(acw_pkg::HYS_LARGE_LSB);
		endcase
		// a high result must fall by the hysteresis before it drops
		if (raw_s)
			raw_d = ({1'b0, pos_v} + hys_v) > {1'b0, neg_v};
		else
			raw_d = {1'b0, pos_v} > ({1'b0, neg_v} + hys_v);
		raw_d = raw_d && sel_ok && en_q;
	end

	// raw result crosses into the clocked logic
	acw_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (raw_d),
		.q       (raw_s)
	);

	// start-up timer started by the enable
	acw_startup #(.CYCLES(STARTUP_CYCLES)) u_startup (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (en_q),
		.ready_q (ready_q)
	);

	// --------------------------------------------------------------------
	// output level, pin and event
	// --------------------------------------------------------------------
	logic out_q;     // comparator output level
	logic live_q;    // out_q carries the comparison
	logic out_p_q;   // out_q one clock back
	logic live_p_q;  // live_q one clock back
	logic edge_hit;  // selected edge seen

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{out_q, live_q, out_p_q, live_p_q} <= '0;
			current_comparator <= 1'b0;
		end
		else
		begin
			if (ready_q)
				out_q <= raw_s ^ pol_q;
			else
				out_q <= init_q;
			live_q   <= ready_q;
			out_p_q  <= out_q;
			live_p_q <= live_q;
			current_comparator <= raw_s && ready_q;  // level for window partners
		end
	end

	// no event input exists; the level event is the output itself
	assign cmp_out_pin    = out_q;
	assign cmp_event      = out_q;
	assign cmp_out_pin_oe = pad_oe_q;
	assign hysteresis_select = hys_q;
	assign power_profile     = power_q;

	// edge select in normal mode
	always_comb
	begin
		edge_hit = 1'b0;
		if (live_q && live_p_q && (out_q != out_p_q))
		begin
			case (mode_q)
				acw_pkg::TRIG_BOTH: edge_hit = 1'b1;
				acw_pkg::TRIG_FALL: edge_hit = !out_q;
				acw_pkg::TRIG_RISE: edge_hit = out_q;
				default:            edge_hit = 1'b0;
			endcase
		end
	end

	// --------------------------------------------------------------------
	// window comparator
	// --------------------------------------------------------------------
	logic win_on;   // window mode active
	logic partner;  // partner result: input above lower limit
	logic win_hit;  // state matches trigger mode

	assign win_on  = (partner_q == acw_pkg::WIN_NEXT) || (partner_q == acw_pkg::WIN_SECOND);
	assign partner = (partner_q == acw_pkg::WIN_NEXT) ? partner_comparator_next
		: partner_comparator_second;

	// mode against current window state
	always_comb
	begin
		case (mode_q)
			acw_pkg::TRIG_ABOVE:  win_hit = (win_q == acw_pkg::ACW_WIN_ABOVE);
			acw_pkg::TRIG_INSIDE: win_hit = (win_q == acw_pkg::ACW_WIN_INSIDE);
			acw_pkg::TRIG_BELOW:  win_hit = (win_q == acw_pkg::ACW_WIN_BELOW);
			default:              win_hit = (win_q != acw_pkg::ACW_WIN_INSIDE);
		endcase
	end

	// own comparator holds the upper limit, partner the lower
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			win_q     <= acw_pkg::ACW_WIN_ABOVE;
			match_q   <= 1'b0;
			match_p_q <= 1'b0;
		end
		else
		begin
			if (raw_s)
				win_q <= acw_pkg::ACW_WIN_ABOVE;
			else if (partner)
				win_q <= acw_pkg::ACW_WIN_INSIDE;
			else
				win_q <= acw_pkg::ACW_WIN_BELOW;
			match_q   <= win_on && ready_q && win_hit;
			match_p_q <= match_q;
		end
	end

	// --------------------------------------------------------------------
	// interrupt flag and request; a set beats a clear
	// --------------------------------------------------------------------
	logic flag_set;  // flag event this clock
	logic flag_clr;  // software writes one to the flag

	assign flag_set = win_on ? (match_q && !match_p_q) : edge_hit;
	assign flag_clr = wr && (idx == acw_pkg::IDX_STATUS) && wb[acw_pkg::ST_FLAG];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flag_q  <= 1'b0;
			cmp_irq <= 1'b0;
		end
		else
		begin
			if (flag_set)
				flag_q <= 1'b1;
			else if (flag_clr)
				flag_q <= 1'b0;
			cmp_irq <= flag_q && irq_en_q;
		end
	end

	// --------------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------------
	localparam int READY_BOUND = STARTUP_CYCLES + 2;  // clocks to ready

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_init_hold: assert property (en_q && !ready_q |=> out_q == $past(init_q))
		else $error("output left initial level before ready");
	a_polarity_out: assert property (ready_q |=> out_q == ($past(raw_s) ^ $past(pol_q)))
		else $error("output is not raw result xor polarity");
	a_ready_time: assert property ($rose(en_q) |-> ##[1:READY_BOUND] (ready_q || !en_q))
		else $error("start-up did not end in time");
	a_ready_off: assert property (!en_q |=> !ready_q)
		else $error("ready while disabled");
	a_flag_sticky: assert property (flag_q && !flag_clr |=> flag_q ##1 (flag_q || $past(flag_clr)))
		else $error("flag dropped without clear");
	a_rise_flag: assert property (!win_on && mode_q == acw_pkg::TRIG_RISE
		&& live_p_q && live_q && $rose(out_q) |=> flag_q)
		else $error("rising edge missed");
	a_irq_gate: assert property (cmp_irq |-> $past(irq_en_q) && $past(flag_q))
		else $error("interrupt without enable and flag");
	a_win_inside: assert property (!raw_s && partner |=> win_q == acw_pkg::ACW_WIN_INSIDE)
		else $error("window state not inside");
	a_match_state: assert property (!win_on |=> !match_q)
		else $error("match set outside window mode");
	a_event_level: assert property (ready_q |=> cmp_event == ($past(raw_s) ^ $past(pol_q)))
		else $error("event does not follow comparator level");

	c_window_inside: cover property (win_on && match_q && win_q == acw_pkg::ACW_WIN_INSIDE);
	c_flag_set: cover property (flag_set && flag_clr);
	c_edge_rise: cover property (edge_hit && out_q ##1 flag_q);

endmodule // acw_comparator_window

// ### test/acw_analog_model.sv
// behavioural analog side: pins, reference and the partner comparator
`timescale 1ns/1ps
module acw_analog_model #(
	parameter int W = 10  // analog sample width
)
(
	input  wire logic              pclk,
	input  wire logic [3:0][W-1:0] pos_set,
	input  wire logic [2:0][W-1:0] neg_set,
	input  wire logic [W-1:0]      vref_set,
	input  wire logic [W-1:0]      lower,
	output logic      [3:0][W-1:0] pos,
	output logic      [2:0][W-1:0] neg,
	output logic      [W-1:0]      vref,
	output logic                   above_lower
);
	// pins settle one clock after the bench asks; partner watches pin 0 too
	always_ff @(posedge pclk)
	begin
		pos         <= pos_set;
		neg         <= neg_set;
		vref        <= vref_set;
		above_lower <= pos_set[0] > lower;
	end
endmodule // acw_analog_model

// ### test/acw_comparator_window_test.sv
// self-checking bench for the comparator window logic
`timescale 1ns/1ps
module acw_comparator_window_test;
	localparam int W = 10;
	logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]       paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rd;
	logic              pready, pslverr, err, cmp_out_pin, cmp_out_pin_oe, cmp_event;
	logic              cmp_irq, cur, part, sec = 0;
	logic [3:0][W-1:0] pos_set = '0, pos;
	logic [2:0][W-1:0] neg_set = '0, neg;
	logic [W-1:0]      vr_set = '0, vr, lower = '0;
	logic [1:0]        hys, pwr, s, m;
	logic [2:0]        ps, ns;
	logic              pol;
	logic [7:0]        rl;
	int                fails = 0, n_tests = 0, cyc = 0;
	always #2.5 pclk = ~pclk;
	acw_comparator_window #(.STARTUP_CYCLES(8)) acw_comparator_window_i (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.positive_analog_pin(pos), .negative_analog_pin(neg), .vref_level(vr),
		.partner_comparator_next(part && !sec), .partner_comparator_second(part && sec),
		.current_comparator(cur), .cmp_out_pin, .cmp_out_pin_oe, .cmp_event,
		.cmp_irq, .hysteresis_select(hys), .power_profile(pwr));
	acw_analog_model #(.W(W)) acw_analog_model_i (.pclk, .pos_set, .neg_set,
		.vref_set(vr_set), .lower, .pos, .neg, .vref(vr), .above_lower(part));
	task automatic end_of_test();
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// one apb transfer to a register index, held until pready
	task automatic apb(input logic w, input logic [2:0] i, input logic [7:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {7'h00, i, 2'h0};
		pwdata  <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk iff pready === 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	function automatic logic exp_raw(logic [2:0] p, logic [2:0] n);
		logic [W-1:0] nv;
		nv = (n == 3'h3) ? W'((18'(rl) * 18'(vr_set)) >> 8) : neg_set[n];
		return pos_set[p] > nv;
	endfunction
	// hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			end_of_test();
		end
	end
	initial
	begin
		void'($urandom(17008));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			apb(1'b0, 3'(k), 8'h00);
			chk(rd, (k == 7) ? 32'h0000_0080 : 32'h0000_0000);
			chk(err, k == 3 || k == 4);
		end
		apb(1'b1, 3'h2, 8'h40);
		apb(1'b1, 3'h0, 8'h41);
		settle(2);
		chk(cmp_out_pin, 1'b1);
		settle(12);
		chk(cmp_out_pin, 1'b0);
		chk(cmp_out_pin_oe, 1'b1);
		for (int t = 0; t < 24; t++)
		begin
			foreach (pos_set[j]) pos_set[j] <= W'($urandom);
			foreach (neg_set[j]) neg_set[j] <= W'($urandom);
			vr_set <= W'($urandom);
			ps = 3'($urandom_range(3, 0));
			ns = 3'($urandom_range(3, 0));
			pol = 1'($urandom);
			rl = 8'($urandom);
			apb(1'b1, 3'h5, rl);
			apb(1'b1, 3'h2, {pol, 1'b0, ps, ns});
			settle(6);
			chk(cmp_out_pin, exp_raw(ps, ns) ^ pol);
			chk(cmp_event, cmp_out_pin);
		end
		vr_set <= 10'h200;
		apb(1'b1, 3'h5, 8'h80);
		for (int v = 0; v < 2; v++)
		begin
			pos_set[1] <= W'(16'h0100 + v);
			apb(1'b1, 3'h2, 8'h0b);
			settle(6);
			chk(cmp_out_pin, v);
		end
		pos_set[0] <= '0;
		neg_set[0] <= 10'h100;
		apb(1'b1, 3'h2, 8'h00);
		apb(1'b1, 3'h6, 8'h31);
		apb(1'b1, 3'h7, 8'h01);
		pos_set[0] <= 10'h200;
		settle(16);
		chk(cmp_irq, 1'b1);
		apb(1'b1, 3'h6, 8'h30);
		settle(3);
		chk(cmp_irq, 1'b0);
		apb(1'b1, 3'h6, 8'h31);
		apb(1'b1, 3'h7, 8'h01);
		pos_set[0] <= '0;
		settle(6);
		chk(cmp_irq, 1'b0);
		neg_set[0] <= 10'h200;
		lower <= 10'h100;
		apb(1'b1, 3'h1, 8'h01);
		for (int k = 0; k < 12; k++)
		begin
			s = 2'(2 - k / 4);
			m = 2'(k % 4);
			pos_set[0] <= W'(16'h0080 + (k / 4) * 16'h0100);
			sec <= k[0];
			apb(1'b1, 3'h1, {6'h00, k[0], ~k[0]});
			apb(1'b1, 3'h6, {2'h0, m, 4'h0});
			settle(8);
			apb(1'b0, 3'h7, 8'h00);
			chk(rd[7:4], {s, 1'b0, (m == 2'h3) ? s != 2'h1 : m == s});
			chk(cur, s == 2'h0);
		end
		apb(1'b1, 3'h0, 8'h4d);
		apb(1'b0, 3'h0, 8'h00);
		chk(rd, 32'h0000_004d);
		chk(hys, 2'h2);
		chk(pwr, 2'h1);
		end_of_test();
	end
endmodule // acw_comparator_window_test
